//--- common/dpwc_pkg.sv
package dpwc_pkg;
  // pin and word widths, and the clock period
  localparam int ADDR_W = 13;
  localparam int DATA_W = 9;
  localparam int CLK_PERIOD_NS = 100;
  // write timing, ns as printed (slowest grade kept as defaults)
  localparam int T_ADDR_SETUP_NS = 0;
  localparam int T_WRITE_PULSE_NS = 25;
  localparam int T_OUT_HIGHZ_NS = 20;
  localparam int T_DATA_SETUP_NS = 15;
  localparam int T_WRITE_REC_NS = 2;
  localparam int T_DATA_HOLD_NS = 0;
  localparam int T_FLAG_WR_RD_NS = 5;
  localparam int T_READ_ACCESS_NS = 35;
  // least times round up, at least one cycle
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_up
  localparam int WP_CYC = cyc_up(T_WRITE_PULSE_NS);
  localparam int WPOE_CYC = cyc_up(T_OUT_HIGHZ_NS + T_DATA_SETUP_NS);
  localparam int AS_CYC = cyc_up(T_ADDR_SETUP_NS);
  localparam int WR_CYC = cyc_up(T_WRITE_REC_NS);
  localparam int DH_CYC = cyc_up(T_DATA_HOLD_NS);
  localparam int SWRD_CYC = cyc_up(T_FLAG_WR_RD_NS);
  localparam int RD_CYC = cyc_up(T_READ_ACCESS_NS);
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_RST = 4'h0;
  // request carried from the user side
  typedef struct packed {
    logic              flag;   // 1 = semaphore flag, 0 = array
    logic              rd_back; // read flag back after write
    logic              oe_low;  // keep output enable low until strobe falls
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } dpwc_req_t;
  // pin bundle toward the memory port
  typedef struct packed {
    logic              sel_n;
    logic              flag_select_n;
    logic              we_n;
    logic              oe_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dout;
    logic              doe;
  } dpwc_pins_t;
  localparam dpwc_pins_t PINS_IDLE = '{sel_n: 1'b1, flag_select_n: 1'b1, we_n: 1'b1,
                                     oe_n: 1'b1, addr: 13'h0000, dout: 9'h000,
                                     doe: 1'b0};
endpackage : dpwc_pkg

//--- hdl/dpwc_delay.sv
`timescale 1ns/1ns
// loadable down counter; busy until the last loaded cycle
module dpwc_delay #(
  parameter int CW = 4
) (
  input  wire logic          i_sys_clk,
  input  wire logic          i_reset_n,
  input  wire logic          i_load,
  input  wire logic [CW-1:0] i_count,
  output logic               o_busy
);
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;

  // load wins over counting so back-to-back phases chain cleanly
  always_comb begin
    cnt_nxt = cnt_r;
    if (i_load) begin
      cnt_nxt = i_count;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // load is not fed back: the host decides to load from busy, a loop otherwise
  assign o_busy = (cnt_r > CW'(1));
endmodule : dpwc_delay

//--- hdl/dpwc_host.sv
`timescale 1ns/1ns
// Contract
// RQ1 - array: select low, flag select high; flag: opposite; held whole write
// RQ2 - address changes only while select and write strobe are high
// RQ3 - device writes while select and strobe both low; ends first rising
// RQ4 - honour write recovery after strobe rises before next cycle
// RQ5 - do not drive data while port may still drive its pins
// RQ6 - select falling with or after strobe keeps device outputs off
// RQ7 - with output enable low, pulse is max of width or turnoff plus setup
// RQ8 - with output enable high, plain minimum pulse width is enough
// RQ9 - hold write data at least hold time after write end
// RQ10 - device hold shorter than its output re-enable delay
// RQ11 - port select stays high over flag write and following flag read
// RQ12 - flag read returns all nine data lines equal to flag state
// RQ13 - wait flag write-to-read time before reading flag back
// RQ14 - flag contention: winner assured only with 5 ns margin
// RQ15 - winner undetermined when contention window is missed
// RQ16 - device captures data at first rising select or strobe
module dpwc_host (
  input  wire logic                     i_sys_clk,
  input  wire logic                     i_reset_n,
  input  wire logic                     i_req_valid,
  input  wire dpwc_pkg::dpwc_req_t      i_req,
  output logic                          o_req_ready,
  output logic                          o_done,
  output logic                          o_flag_valid,
  output logic                          o_flag_value,
  output logic                          o_flag_mixed,
  input  wire logic [dpwc_pkg::DATA_W-1:0] i_mem_din,
  output dpwc_pkg::dpwc_pins_t          o_pins
);
  typedef enum logic [6:0] {
    ST_IDLE  = 7'b0000001,
    ST_SETUP = 7'b0000010,
    ST_PULSE = 7'b0000100,
    ST_HOLD  = 7'b0001000,
    ST_REC   = 7'b0010000,
    ST_GAP   = 7'b0100000,
    ST_READ  = 7'b1000000
  } dpwc_state_t;

  dpwc_state_t          state_r, state_nxt;
  dpwc_pkg::dpwc_req_t  req_r, req_nxt;
  dpwc_pkg::dpwc_pins_t pins_r, pins_nxt;
  logic                 ready_r, ready_nxt;
  logic                 done_r, done_nxt;
  logic                 fvalid_r, fvalid_nxt;
  logic                 fvalue_r, fvalue_nxt;
  logic                 fmixed_r, fmixed_nxt;
  logic                 ld;
  logic [dpwc_pkg::CNT_W-1:0] ld_cnt;
  logic                 wait_busy;

  // all phase timing comes from one shared counter
  dpwc_delay #(.CW(dpwc_pkg::CNT_W)) u_delay (
    .i_sys_clk (i_sys_clk),
    .i_reset_n (i_reset_n),
    .i_load    (ld),
    .i_count   (ld_cnt),
    .o_busy    (wait_busy)
  );

  // pulse length depends on whether outputs were allowed on
  function automatic logic [dpwc_pkg::CNT_W-1:0] pulse_len(input logic oe_low);
    int n;
    n = dpwc_pkg::WP_CYC;
    if (oe_low && dpwc_pkg::WPOE_CYC > n) begin
      n = dpwc_pkg::WPOE_CYC; // [RQ7]
    end
    return dpwc_pkg::CNT_W'(n); // [RQ8]
  endfunction : pulse_len

  // sequencing of one write and optional flag read-back
  always_comb begin
    state_nxt  = state_r;
    req_nxt    = req_r;
    pins_nxt   = pins_r;
    ready_nxt  = 1'b0;
    done_nxt   = 1'b0;
    fvalid_nxt = 1'b0;
    fvalue_nxt = fvalue_r;
    fmixed_nxt = fmixed_r;
    ld         = 1'b0;
    ld_cnt     = dpwc_pkg::CNT_RST;
    case (state_r)
      ST_IDLE: begin
        ready_nxt = 1'b1;
        if (i_req_valid && ready_r) begin
          ready_nxt = 1'b0;
          req_nxt   = i_req;
          // address moves while strobe and select are high
          pins_nxt.addr = i_req.addr; // [RQ2]
          pins_nxt.oe_n = ~i_req.oe_low;
          // select a cycle before strobe, so with output enable low the device may already drive
          pins_nxt.sel_n         = i_req.flag; // [RQ1]
          pins_nxt.flag_select_n = ~i_req.flag; // [RQ1]
          ld        = 1'b1;
          ld_cnt    = dpwc_pkg::CNT_W'(dpwc_pkg::AS_CYC);
          state_nxt = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (!wait_busy) begin
          // strobe falls first, data only after; outputs may still be on
          pins_nxt.we_n = 1'b0; // [RQ3]
          pins_nxt.oe_n = 1'b1;
          ld        = 1'b1;
          ld_cnt    = pulse_len(req_r.oe_low);
          state_nxt = ST_PULSE;
        end
      end
      ST_PULSE: begin
        // drive data one cycle into the pulse, after turnoff begins
        pins_nxt.dout = req_r.data;
        pins_nxt.doe  = 1'b1; // [RQ5]
        if (!wait_busy && pins_r.doe) begin
          // strobe rises only after data stood a full cycle; device takes data here
          pins_nxt.we_n = 1'b1; // [RQ16]
          // a flag write completes on this edge; cross-port margin is the system's
          pins_nxt.flag_select_n = pins_r.flag_select_n; // [RQ14]
          ld        = 1'b1;
          ld_cnt    = dpwc_pkg::CNT_W'(dpwc_pkg::DH_CYC);
          state_nxt = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (!wait_busy) begin
          pins_nxt.doe = 1'b0; // [RQ9]
          if (!(req_r.flag && req_r.rd_back)) begin
            pins_nxt.sel_n         = 1'b1;
            pins_nxt.flag_select_n = 1'b1;
          end else begin
            pins_nxt.flag_select_n = 1'b1; // [RQ11]
          end
          ld        = 1'b1;
          ld_cnt    = dpwc_pkg::CNT_W'(dpwc_pkg::WR_CYC);
          state_nxt = ST_REC;
        end
      end
      ST_REC: begin
        if (!wait_busy) begin // [RQ4]
          if (req_r.flag && req_r.rd_back) begin
            ld        = 1'b1;
            ld_cnt    = dpwc_pkg::CNT_W'(dpwc_pkg::SWRD_CYC);
            state_nxt = ST_GAP;
          end else begin
            done_nxt  = 1'b1;
            state_nxt = ST_IDLE;
          end
        end
      end
      ST_GAP: begin
        if (!wait_busy) begin // [RQ13]
          pins_nxt.flag_select_n = 1'b0;
          pins_nxt.oe_n          = 1'b0;
          ld        = 1'b1;
          ld_cnt    = dpwc_pkg::CNT_W'(dpwc_pkg::RD_CYC);
          state_nxt = ST_READ;
        end
      end
      ST_READ: begin
        if (!wait_busy) begin
          // all nine lines should agree; a mismatch is reported
          fvalue_nxt = i_mem_din[0]; // [RQ12]
          fmixed_nxt = !((&i_mem_din) || (~|i_mem_din)); // [RQ12]
          fvalid_nxt = 1'b1;
          pins_nxt   = dpwc_pkg::PINS_IDLE;
          pins_nxt.addr = pins_r.addr;
          done_nxt   = 1'b1;
          state_nxt  = ST_IDLE;
        end
      end
      default: begin
        pins_nxt  = dpwc_pkg::PINS_IDLE;
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // state registers
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      state_r  <= ST_IDLE;
      req_r    <= '0;
      pins_r   <= dpwc_pkg::PINS_IDLE;
      ready_r  <= 1'b0;
      done_r   <= 1'b0;
      fvalid_r <= 1'b0;
      fvalue_r <= 1'b0;
      fmixed_r <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      req_r    <= req_nxt;
      pins_r   <= pins_nxt;
      ready_r  <= ready_nxt;
      done_r   <= done_nxt;
      fvalid_r <= fvalid_nxt;
      fvalue_r <= fvalue_nxt;
      fmixed_r <= fmixed_nxt;
    end
  end

  assign o_req_ready  = ready_r;
  assign o_done       = done_r;
  assign o_flag_valid = fvalid_r;
  assign o_flag_value = fvalue_r;
  assign o_flag_mixed = fmixed_r;
  assign o_pins       = pins_r;
endmodule : dpwc_host

//--- sim/dpwc_host_asserts.sv
`timescale 1ns/1ns
// pin ordering and handshake checks on the write port
module dpwc_host_asserts (
  input wire logic                    i_sys_clk,
  input wire logic                    i_reset_n,
  input wire logic                    i_req_valid,
  input wire dpwc_pkg::dpwc_req_t     i_req,
  input wire logic                    o_req_ready,
  input wire logic                    o_done,
  input wire logic                    o_flag_valid,
  input wire logic                    o_flag_value,
  input wire logic                    o_flag_mixed,
  input wire logic [8:0]              i_mem_din,
  input wire dpwc_pkg::dpwc_pins_t    o_pins
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  sel_excl_a: assert property (o_pins.sel_n || o_pins.flag_select_n)
    else $error("both selects low");
  sel_hold_a: assert property (!o_pins.we_n |-> $stable({o_pins.sel_n, o_pins.flag_select_n}))
    else $error("select moved in write");
  addr_quiet_a: assert property (!$stable(o_pins.addr) |-> o_pins.we_n && $past(o_pins.we_n))
    else $error("address moved in write");
  drive_late_a: assert property ($rose(o_pins.doe) |-> !o_pins.we_n && $past(!o_pins.we_n))
    else $error("data driven too early");
  pulse_len_a: assert property ($fell(o_pins.we_n) |-> ##1 !o_pins.we_n)
    else $error("write pulse too short");
  data_setup_a: assert property ($rose(o_pins.we_n) |-> $past(o_pins.doe))
    else $error("no data before write end");
  data_hold_a: assert property ($rose(o_pins.we_n) |-> o_pins.doe && $stable(o_pins.dout))
    else $error("data not held");
  recovery_a: assert property ($rose(o_pins.we_n) |=> o_pins.we_n [*2])
    else $error("no write recovery");
  flag_gap_a: assert property ($rose(o_pins.we_n) && !o_pins.flag_select_n |=> o_pins.oe_n)
    else $error("flag read too soon");
  take_drop_a: assert property (i_req_valid && o_req_ready |=> !o_req_ready ##1 !o_req_ready)
    else $error("ready stayed high");
  flag_done_a: assert property (o_flag_valid |-> o_done && $past(o_pins.sel_n))
    else $error("flag result unpaired");
endmodule : dpwc_host_asserts

bind dpwc_host dpwc_host_asserts dpwc_host_asserts_i (.i_sys_clk, .i_reset_n, .i_req_valid,
  .i_req, .o_req_ready, .o_done, .o_flag_valid, .o_flag_value, .o_flag_mixed, .i_mem_din,
  .o_pins);

//--- sim/dpwc_port_model.sv
`timescale 1ns/1ns
// behavioural memory port: array, eight flags, bus contention watch
module dpwc_port_model (
  input  wire dpwc_pkg::dpwc_pins_t i_pins,
  input  wire logic                 i_bad,
  output logic [8:0]                o_din,
  output logic                      o_err
);
  logic [8:0] mem [0:8191];
  logic [7:0] flg = 8'hff;
  logic [8:0] held = 9'h000;
  logic [8:0] rd;
  wire wr_arr = !i_pins.sel_n && !i_pins.we_n;
  wire wr_flg = !i_pins.flag_select_n && !i_pins.we_n;
  // outputs only with oe low and strobe high, so a late select stays quiet
  wire drv = !i_pins.oe_n && i_pins.we_n && !(i_pins.sel_n && i_pins.flag_select_n);
  initial o_err = 1'b0;
  // capture at the end of the overlap
  always @(negedge wr_arr) mem[i_pins.addr] = i_pins.dout;
  // single port, so the written value simply wins
  always @(negedge wr_flg) flg[i_pins.addr[2:0]] = i_pins.dout[0];
  // flag read puts one value on all nine lines unless told to misbehave
  always @* begin
    rd = i_pins.sel_n ? {9{flg[i_pins.addr[2:0]]}} ^ {i_bad, 8'h00} : mem[i_pins.addr];
    if (drv) held = rd;
  end
  // released lines show the inverse of the last value
  assign o_din = drv ? rd : ~held;
  always @* if (drv && i_pins.doe) o_err = 1'b1;
endmodule : dpwc_port_model

//--- sim/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic                  i_sys_clk = 1'b0;
  logic                  i_reset_n = 1'b0;
  logic                  i_req_valid = 1'b0;
  dpwc_pkg::dpwc_req_t   i_req = '0;
  logic                  o_req_ready, o_done, o_flag_valid, o_flag_value, o_flag_mixed;
  logic [8:0]            i_mem_din;
  dpwc_pkg::dpwc_pins_t  o_pins;
  logic                  bad = 1'b0;
  logic                  m_err;
  int                    n_mismatch = 0;
  int                    checks = 0;
  int                    cyc = 0;
  logic [31:0]           r;
  always #50 i_sys_clk = ~i_sys_clk;
  dpwc_host dpwc_host_i (.i_sys_clk, .i_reset_n, .i_req_valid, .i_req, .o_req_ready,
    .o_done, .o_flag_valid, .o_flag_value, .o_flag_mixed, .i_mem_din, .o_pins);
  dpwc_port_model dpwc_port_model_i (.i_pins(o_pins), .i_bad(bad), .o_din(i_mem_din),
    .o_err(m_err));
  function automatic logic [8:0] exp_mem(input logic f, input logic [8:0] d);
    return f ? {8'h00, d[0]} : d;
  endfunction : exp_mem
  task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  // one request, waits for ready then for done under a bound
  task automatic xfer(input logic f, input logic rb, input logic oe,
                      input logic [12:0] a, input logic [8:0] d);
    int n;
    i_req = '{flag: f, rd_back: rb, oe_low: oe, addr: a, data: d};
    i_req_valid = 1'b1;
    n = 0;
    while (o_req_ready !== 1'b1 && n < 50) begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end
    @(posedge i_sys_clk);
    #1;
    i_req_valid = 1'b0;
    n = 0;
    while (o_done !== 1'b1 && n < 50) begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end
    chk("done", 9'h001, {8'h00, o_done});
    chk("flag_valid", {8'h00, f && rb}, {8'h00, o_flag_valid});
    if (f && rb) begin
      chk("flag_value", {8'h00, d[0]}, {8'h00, o_flag_value});
      chk("flag_mixed", {8'h00, bad}, {8'h00, o_flag_mixed});
    end
    if (f) chk("flag", exp_mem(f, d), {8'h00, dpwc_port_model_i.flg[a[2:0]]});
    else chk("mem", exp_mem(f, d), dpwc_port_model_i.mem[a]);
  endtask : xfer
  // run-length guard
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      test_done();
    end
  end
  initial begin
    void'($urandom(32'h5fbe526e));
    repeat (12) @(posedge i_sys_clk);
    #1;
    i_reset_n = 1'b1;
    // corners: ends of address and data, both output enable modes
    xfer(1'b0, 1'b0, 1'b1, 13'h0000, 9'h1ff);
    xfer(1'b0, 1'b0, 1'b0, 13'h1fff, 9'h000);
    xfer(1'b1, 1'b1, 1'b1, 13'h0000, 9'h000);
    xfer(1'b1, 1'b1, 1'b0, 13'h0007, 9'h001);
    bad = 1'b1;
    xfer(1'b1, 1'b1, 1'b0, 13'h0003, 9'h001);
    bad = 1'b0;
    for (int i = 0; i < 24; i++) begin
      r = $urandom;
      xfer(r[0], r[1], r[2], r[15:3], r[24:16]);
    end
    chk("contention", 9'h000, {8'h00, m_err});
    test_done();
  end
endmodule : tb_top
